/* File: design/swl_pkg.sv */
package swl_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 20;
    localparam int T_PIN_UP_US      = 1000;  // supply on to pin raise, least
    localparam int T_RESUME_US      = 700;   // resume wait, longest
    localparam int T_RESP_US        = 2000;  // answer wait, longest
    localparam int PIN_UP_CYC       = T_PIN_UP_US * CLK_MHZ;
    localparam int RESUME_CYC       = T_RESUME_US * CLK_MHZ;
    localparam int RESP_CYC         = T_RESP_US * CLK_MHZ;
    localparam int DEACT_CYC        = 64;    // pin low before supply drops
    localparam int TIMER_W          = 16;
    // ------------------------------------------------------------
    // line coding: bit period and high times of a 0 and a 1
    // ------------------------------------------------------------
    localparam int BIT_CYC          = 20;
    localparam int HIGH0_CYC        = 5;
    localparam int HIGH1_CYC        = 15;
    localparam int SAMPLE_AT        = HIGH0_CYC - 1;
    localparam int MAX_REPEATS      = 3;
    // ------------------------------------------------------------
    // activation frame types from the frame decoder
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FT_SYNC  = 2'h0,
        FT_READY = 2'h1,
        FT_OTHER = 2'h2
    } swl_frame_type;
    typedef enum logic [2:0] {
        ST_OFF    = 3'h0,
        ST_PWRUP  = 3'h1,
        ST_RESUME = 3'h2,
        ST_SYNC   = 3'h3,
        ST_RESP   = 3'h4,
        ST_DONE   = 3'h5,
        ST_FAIL   = 3'h6,
        ST_DEACT  = 3'h7
    } swl_state_type;
endpackage

/* File: design/swl_line_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface swl_line_if;
    logic line_on;
    logic tx_bit;
    logic bit_en;
    logic rx_bit;
    logic rx_valid;
    modport ctrl (output line_on, output tx_bit,
                  input bit_en, input rx_bit, input rx_valid);
    modport line (input line_on, input tx_bit,
                  output bit_en, output rx_bit, output rx_valid);
endinterface
`default_nettype wire

/* File: design/swl_pwm_line.sv */
`timescale 1ns/1ps
`default_nettype none
module swl_pwm_line
    import swl_pkg::*;
(
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic slave_current_signal,
    output logic      master_voltage_signal,
    swl_line_if.line  lk
);
    typedef struct packed {
        logic [4:0] cnt;
        logic       bitval;
        logic       s2_meta;
        logic       s2_sync;
        logic       rx_bit;
        logic       rx_valid;
        logic       s1;
    } swl_line_type;

    swl_line_type cur_ff, nxt_cur;
    logic [4:0] high_len;

    // ------------------------------------------------------------
    // pulse width coder: the wire carries clock and data together
    // ------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.s2_meta = slave_current_signal;
        nxt_cur.s2_sync = cur_ff.s2_meta;
        nxt_cur.rx_valid = 1'b0;
        if (cur_ff.cnt == 5'(BIT_CYC - 1)) begin
            nxt_cur.cnt = 5'h00;
            nxt_cur.bitval = lk.tx_bit;
        end else begin
            nxt_cur.cnt = cur_ff.cnt + 5'h01;
        end
        high_len = cur_ff.bitval ? 5'(HIGH1_CYC) : 5'(HIGH0_CYC);
        // line held low whenever off
        nxt_cur.s1 = lk.line_on && (nxt_cur.cnt < high_len);
        // current read only inside the high part of a bit
        if (lk.line_on && cur_ff.cnt == 5'(SAMPLE_AT)) begin
            nxt_cur.rx_bit = cur_ff.s2_sync;
            nxt_cur.rx_valid = 1'b1;
        end
        // parked at the bit end so the first pulse after the rise is whole
        if (!lk.line_on) begin
            nxt_cur.bitval = 1'b0;
            nxt_cur.cnt = 5'(BIT_CYC - 1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign lk.bit_en             = lk.line_on &&
                                   (cur_ff.cnt == 5'(BIT_CYC - 1));
    assign lk.rx_bit             = cur_ff.rx_bit;
    assign lk.rx_valid           = cur_ff.rx_valid;
    assign master_voltage_signal = cur_ff.s1;

    initial begin
        if (HIGH0_CYC < 3 || HIGH1_CYC >= BIT_CYC || BIT_CYC > 31) begin
            $error("unusable line coding constants");
        end
    end

    sample_in_high_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        cur_ff.rx_valid |-> $past(cur_ff.s1, 2))
        else $error("current sampled outside high time");
endmodule
`default_nettype wire

/* File: design/swl_master_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module swl_master_ctrl
    import swl_pkg::*;
#(
    parameter int PIN_UP_CYCLES = PIN_UP_CYC,
    parameter int RESUME_CYCLES = RESUME_CYC,
    parameter int RESP_CYCLES   = RESP_CYC
) (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   supply_req,
    input  wire logic                   full_power,
    input  wire logic                   tx_line_bit,
    input  wire logic                   rx_frame_valid,
    input  wire logic                   rx_frame_ok,
    input  wire swl_pkg::swl_frame_type rx_frame_type,
    input  wire logic                   slave_current_signal,
    output logic                        master_voltage_signal,
    output logic                        master_voltage_oe,
    output logic                        supply_enable,
    output logic                        line_bit_en,
    output logic                        rx_line_bit,
    output logic                        rx_line_valid,
    output logic                        tx_frame_req,
    output logic                        tx_frame_repeat_bit,
    output logic                        tx_full_power,
    output logic                        link_active,
    output logic                        card_no_support
);
    import swl_pkg::*;

    typedef struct packed {
        swl_state_type        st;
        logic [TIMER_W-1:0]   timer;
        logic [1:0]           repeats;
        logic                 first_sync;
        logic                 fr_sent;
        logic                 supply;
        logic                 req;
        logic                 req_fr;
        logic                 req_pw;
    } swl_ctrl_type;

    swl_ctrl_type cur_ff, nxt_cur;
    swl_line_if   lk();
    logic         resumed;
    logic         good_sync;
    logic         good_ready;
    logic         timeout;

    swl_pwm_line u_line (
        .mclk                 (mclk),
        .reset_n              (reset_n),
        .slave_current_signal (slave_current_signal),
        .master_voltage_signal(master_voltage_signal),
        .lk                   (lk)
    );

    initial begin
        if (RESP_CYCLES >= 2**TIMER_W || PIN_UP_CYCLES >= 2**TIMER_W ||
            RESUME_CYCLES >= 2**TIMER_W || RESUME_CYCLES < 1) begin
            $error("timer too narrow for chosen counts");
        end
    end

    // ------------------------------------------------------------
    // frame classification
    // ------------------------------------------------------------
    assign resumed    = lk.rx_valid && lk.rx_bit;
    assign good_sync  = rx_frame_valid && rx_frame_ok &&
                        rx_frame_type == FT_SYNC;
    assign good_ready = rx_frame_valid && rx_frame_ok &&
                        rx_frame_type == FT_READY;
    assign timeout    = (cur_ff.timer == '0);

    // ------------------------------------------------------------
    // activation sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.req = 1'b0;
        if (!timeout) begin
            nxt_cur.timer = cur_ff.timer - 1'b1;
        end
        unique case (cur_ff.st)
            ST_OFF: begin
                if (supply_req) begin
                    nxt_cur.st = ST_PWRUP;
                    nxt_cur.supply = 1'b1;
                    nxt_cur.timer = TIMER_W'(PIN_UP_CYCLES);
                end
            end
            ST_PWRUP: begin
                if (timeout) begin
                    nxt_cur.st = ST_RESUME;  // pin rises
                    nxt_cur.timer = TIMER_W'(RESUME_CYCLES);
                end
            end
            ST_RESUME: begin
                if (resumed) begin
                    nxt_cur.st = ST_SYNC;
                    nxt_cur.timer = TIMER_W'(RESP_CYCLES);
                end else if (timeout) begin
                    nxt_cur.st = ST_FAIL;
                end
            end
            ST_SYNC: begin
                nxt_cur.req = 1'b1;
                if (good_sync && full_power) begin
                    nxt_cur.first_sync = 1'b1;
                    nxt_cur.req_fr = 1'b0;
                end else if (good_sync) begin
                    nxt_cur.st = ST_DONE;
                    nxt_cur.req = 1'b0;
                end else if (rx_frame_valid || timeout) begin
                    nxt_cur.req_fr = 1'b1;
                    nxt_cur.repeats = 2'h1;
                end else begin
                    nxt_cur.req = 1'b0;
                end
                if (nxt_cur.req) begin
                    nxt_cur.st = ST_RESP;
                    nxt_cur.req_pw = full_power;
                    nxt_cur.fr_sent = nxt_cur.req_fr;
                    nxt_cur.timer = TIMER_W'(RESP_CYCLES);
                end
            end
            ST_RESP: begin
                if ((good_sync && cur_ff.fr_sent) ||
                    (good_ready && cur_ff.first_sync)) begin
                    nxt_cur.st = ST_DONE;
                end else if (rx_frame_valid || timeout) begin
                    // out of order frames fall here too
                    if (cur_ff.repeats == 2'(MAX_REPEATS)) begin
                        nxt_cur.st = ST_FAIL;
                    end else begin
                        nxt_cur.req = 1'b1;
                        nxt_cur.req_fr = 1'b1;
                        nxt_cur.fr_sent = 1'b1;
                        nxt_cur.req_pw = full_power;
                        nxt_cur.repeats = cur_ff.repeats + 2'h1;
                        nxt_cur.timer = TIMER_W'(RESP_CYCLES);
                    end
                end
            end
            ST_DONE, ST_FAIL: begin
            end
            ST_DEACT: begin
                if (timeout) begin
                    nxt_cur.st = ST_OFF;  // supply off only now
                    nxt_cur.supply = 1'b0;
                end
            end
        endcase
        // supply withdrawal: pin goes low first
        if (!supply_req && cur_ff.supply && cur_ff.st != ST_DEACT) begin
            nxt_cur.st = ST_DEACT;
            nxt_cur.req = 1'b0;
            nxt_cur.timer = TIMER_W'(DEACT_CYC);
        end
        if (nxt_cur.st == ST_OFF || nxt_cur.st == ST_PWRUP) begin
            nxt_cur.repeats = 2'h0;
            nxt_cur.first_sync = 1'b0;
            nxt_cur.fr_sent = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin  // only the link's own reset
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------
    // outputs; link state never touches other card interfaces
    // ------------------------------------------------------------
    assign lk.line_on = cur_ff.st inside {ST_RESUME, ST_SYNC, ST_RESP,
                                           ST_DONE};
    assign lk.tx_bit          = tx_line_bit;  // b8 first, as framed
    assign master_voltage_oe  = cur_ff.supply;
    assign supply_enable      = cur_ff.supply;
    assign line_bit_en        = lk.bit_en;
    assign rx_line_bit        = lk.rx_bit;
    assign rx_line_valid      = lk.rx_valid;
    assign tx_frame_req       = cur_ff.req;
    assign tx_frame_repeat_bit= cur_ff.req_fr;
    assign tx_full_power      = cur_ff.req_pw;
    assign link_active        = (cur_ff.st == ST_DONE);
    assign card_no_support    = (cur_ff.st == ST_FAIL);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_good_full_sync;
        cur_ff.st == ST_SYNC && good_sync && full_power;
    endsequence

    sequence s_bad_first;
        cur_ff.st == ST_SYNC && !good_sync && (rx_frame_valid || timeout);
    endsequence

    pin_low_unpowered_a: assert property (
        !supply_enable |-> ##1 !master_voltage_signal)
        else $error("pin high without supply");
    pin_before_supply_a: assert property (
        $fell(supply_enable) |-> !$past(lk.line_on, DEACT_CYC))
        else $error("supply dropped before pin");
    no_resume_fail_a: assert property (
        cur_ff.st == ST_RESUME && timeout && !resumed && supply_req
        |=> card_no_support)
        else $error("missing resume not handled");
    full_power_answer_a: assert property (
        s_good_full_sync ##0 supply_req
        |=> tx_frame_req && !tx_frame_repeat_bit)
        else $error("full power answer wrong");
    low_power_done_a: assert property (
        cur_ff.st == ST_SYNC && good_sync && !full_power && supply_req
        |=> link_active && !tx_frame_req)
        else $error("low power sync not final");
    repeat_first_a: assert property (
        s_bad_first ##0 supply_req |=> tx_frame_req && tx_frame_repeat_bit)
        else $error("no repeat on bad first sync");
    // a fourth request would either wrap the count or follow a full one
    repeat_limit_a: assert property (
        tx_frame_req && tx_frame_repeat_bit
        |-> cur_ff.repeats != 2'h0 &&
            $past(cur_ff.repeats) != 2'(MAX_REPEATS))
        else $error("too many repeat requests");
    sync_after_repeat_a: assert property (
        cur_ff.st == ST_RESP && cur_ff.fr_sent && good_sync && supply_req
        |=> link_active ##1 !tx_frame_req)
        else $error("sync after repeat not accepted");
    fail_pin_low_a: assert property (
        card_no_support |-> ##2 !master_voltage_signal)
        else $error("pin kept up after failure");
endmodule
`default_nettype wire

/* File: dv/swl_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// card end of the link, seen through the frame decoder
// ------------------------------------------------------------
module swl_card_model (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             supply_enable,
    input  wire logic             master_voltage_signal,
    input  wire logic             tx_frame_req,
    input  wire logic             tx_frame_repeat_bit,
    input  wire logic             resume_en,
    input  wire logic [1:0]       first_kind,
    input  wire logic [1:0]       reply_mode,
    input  wire logic [7:0]       reply_dly,
    output logic                  slave_current_signal,
    output var logic              rx_frame_valid,
    output var logic              rx_frame_ok,
    output var swl_pkg::swl_frame_type rx_frame_type
);
    import swl_pkg::*;

    logic          drawing;
    logic          started;
    logic          pend;
    logic          pend_ok;
    logic [7:0]    wait_cnt;
    swl_frame_type pend_type;
    swl_frame_type last_type;
    logic [7:0]    low_cnt;

    // far shorter than the real limit, long enough to ride out a bit
    localparam logic [7:0] INHIBIT_CYC = 8'hc8;

    // current only while the pin is high
    assign slave_current_signal = drawing & master_voltage_signal;

    always @(negedge mclk) begin
        rx_frame_valid <= 1'b0;
        // ok is meaningless between frames, so it toggles on every cycle without a frame while supplied and out of reset
        rx_frame_ok    <= ~rx_frame_ok;
        // line held low for INHIBIT_CYC after start: stop drawing
        if (started && !master_voltage_signal) begin
            low_cnt <= low_cnt + 8'h1;
        end else begin
            low_cnt <= 8'h0;
        end
        if (low_cnt == INHIBIT_CYC) begin
            drawing <= 1'b0;
        end
        if (!reset_n || !supply_enable) begin
            drawing       <= 1'b0;
            started       <= 1'b0;
            pend          <= 1'b0;
            rx_frame_ok   <= 1'b0;
            rx_frame_type <= FT_OTHER;
        end else if (!started && master_voltage_signal && resume_en) begin
            // resume, then first frame with its info field: sync, or ready when first_kind is 2
            drawing   <= 1'b1;
            started   <= 1'b1;
            pend      <= 1'b1;
            wait_cnt  <= 8'h3c;
            // payload abstracted: reserved bytes and bits are zero
            pend_ok   <= first_kind != 2'h1;
            pend_type <= (first_kind == 2'h2) ? FT_READY : FT_SYNC;
        end else if (pend) begin
            if (wait_cnt == 8'h0) begin
                pend           <= 1'b0;
                rx_frame_valid <= 1'b1;
                rx_frame_ok    <= pend_ok;
                rx_frame_type  <= pend_type;
                last_type      <= pend_type;
            end else begin
                wait_cnt <= wait_cnt - 8'h1;
            end
        // mode 2 stays silent, as on a corrupted master frame
        end else if (tx_frame_req && reply_mode != 2'h2) begin
            // repeat last frame on bit 1, ready on bit 0
            pend      <= 1'b1;
            wait_cnt  <= reply_dly;
            pend_ok   <= reply_mode == 2'h0;
            pend_type <= tx_frame_repeat_bit ? last_type : FT_READY;
        end
    end
endmodule
`default_nettype wire

/* File: dv/swl_master_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module swl_master_ctrl_test;
    import swl_pkg::*;
    localparam int PIN_UP = 50;
    localparam int LIMIT  = 3000;
    logic          mclk;
    logic          reset_n     = 1'b0;
    logic          supply_req  = 1'b0;
    logic          full_power  = 1'b0;
    logic          tx_line_bit = 1'b0;
    logic          resume_en   = 1'b0;
    logic [1:0]    first_kind  = 2'h0;
    logic [1:0]    reply_mode  = 2'h0;
    logic [7:0]    reply_dly   = 8'h0;
    logic          pwm_on      = 1'b0;
    int            hi_cnt      = 0;
    int            failures    = 0;
    int            n_tests     = 0;
    int            seed        = 1;
    logic          rx_frame_valid;
    logic          rx_frame_ok;
    swl_frame_type rx_frame_type;
    logic          slave_current_signal;
    logic          master_voltage_signal;
    logic          master_voltage_oe;
    logic          supply_enable;
    logic          tx_frame_req;
    logic          tx_frame_repeat_bit;
    logic          tx_full_power;
    logic          link_active;
    logic          card_no_support;
    logic          line_bit_en;
    logic          rx_line_bit;
    logic          rx_line_valid;

    swl_master_ctrl #(.PIN_UP_CYCLES(PIN_UP), .RESUME_CYCLES(200),
                      .RESP_CYCLES(400)) i_swl_master_ctrl (
        .mclk, .reset_n, .supply_req, .full_power, .tx_line_bit,
        .rx_frame_valid, .rx_frame_ok, .rx_frame_type,
        .slave_current_signal, .master_voltage_signal, .master_voltage_oe,
        .supply_enable, .line_bit_en, .rx_line_bit, .rx_line_valid,
        .tx_frame_req, .tx_frame_repeat_bit, .tx_full_power, .link_active,
        .card_no_support
    );

    swl_card_model i_swl_card_model (
        .mclk, .reset_n, .supply_enable, .master_voltage_signal,
        .tx_frame_req, .tx_frame_repeat_bit, .resume_en, .first_kind,
        .reply_mode, .reply_dly, .slave_current_signal, .rx_frame_valid,
        .rx_frame_ok, .rx_frame_type
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // checking and expectations
    // ------------------------------------------------------------
    task automatic stop_test;
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic int rnd(input int n);
        return ($random(seed) & 32'hffff) % n;
    endfunction

    // good first sync at full power costs one fr=0 request up front
    function automatic int exp_reqs(input bit res, input int fk,
                                    input bit full, input int rm);
        if (!res)
            return 0;
        if (fk == 0)
            return !full ? 0 : (rm == 0 ? 1 : 1 + MAX_REPEATS);
        return (fk == 1 && rm == 0) ? 1 : MAX_REPEATS;
    endfunction

    function automatic bit exp_done(input bit res, input int fk,
                                    input bit full, input int rm);
        return res && (fk == 0 ? (!full || rm == 0) : (fk == 1 && rm == 0));
    endfunction

    // pulse widths, samples and bit ends; a pulse cut by a failed handshake is skipped
    always @(negedge mclk) begin
        tx_line_bit <= 1'($random(seed));
        // the card draws whenever it resumed, so every sample reads that
        if (rx_line_valid === 1'b1)
            check_bit(rx_line_bit, resume_en);
        if (line_bit_en === 1'b1)
            check_bit(master_voltage_signal, 1'b0);
        if (pwm_on && master_voltage_signal === 1'b1) begin
            hi_cnt <= hi_cnt + 1;
        end else begin
            if (pwm_on && hi_cnt != 0 && card_no_support === 1'b0)
                check_bit(hi_cnt == HIGH0_CYC || hi_cnt == HIGH1_CYC, 1'b1);
            hi_cnt <= 0;
        end
    end

    // ------------------------------------------------------------
    // one power-up, handshake and power-down of the card
    // ------------------------------------------------------------
    task automatic activate(input bit res, input int fk, input bit full,
                            input int rm);
        int i;
        int n;
        bit ok;
        n = 0;
        ok = exp_done(res, fk, full, rm);
        resume_en  <= res;
        first_kind <= fk[1:0];
        reply_mode <= rm[1:0];
        reply_dly  <= 8'($random(seed));
        full_power <= full;
        supply_req <= 1'b1;
        pwm_on     <= 1'b1;
        repeat (2) @(negedge mclk);
        check_bit(supply_enable & master_voltage_oe, 1'b1);
        for (i = 0; i < PIN_UP + BIT_CYC && master_voltage_signal !== 1'b1; i++)
            @(negedge mclk);
        check_bit(i >= PIN_UP - 2 && i < PIN_UP + BIT_CYC, 1'b1);
        for (i = 0; i < LIMIT && link_active !== 1'b1
                    && card_no_support !== 1'b1; i++) begin
            @(negedge mclk);
            if (tx_frame_req === 1'b1) begin
                check_bit(tx_frame_repeat_bit, !(n == 0 && fk == 0));
                check_bit(tx_full_power, full);
                n++;
            end
        end
        if (i == LIMIT) begin
            failures++;
            stop_test();
        end
        // no further frames once settled, pin parked low on failure
        for (i = 0; i < 100; i++) begin
            @(negedge mclk);
            if (tx_frame_req === 1'b1)
                n++;
            if (!ok && i > 1)
                check_bit(master_voltage_signal, 1'b0);
        end
        check_cnt(n, exp_reqs(res, fk, full, rm));
        check_bit(link_active, ok);
        check_bit(card_no_support, !ok);
        pwm_on     <= 1'b0;
        supply_req <= 1'b0;
        // pin register follows the state one edge later
        repeat (2) @(negedge mclk);
        check_bit(master_voltage_signal, 1'b0);
        for (i = 0; i < DEACT_CYC - 2; i++) begin
            @(negedge mclk);
            check_bit(supply_enable, 1'b1);
        end
        for (i = 0; i < 6 && supply_enable !== 1'b0; i++)
            @(negedge mclk);
        check_bit(supply_enable, 1'b0);
        for (i = 0; i < 20; i++) begin
            @(negedge mclk);
            check_bit(master_voltage_signal | master_voltage_oe, 1'b0);
        end
    endtask

    initial begin
        repeat (2) @(negedge mclk);
        check_bit(supply_enable | master_voltage_signal | link_active, 1'b0);
        reset_n <= 1'b1;
        activate(1'b0, 0, 1'b1, 0);
        activate(1'b1, 0, 1'b1, 0);
        activate(1'b1, 0, 1'b0, 0);
        activate(1'b1, 1, 1'b1, 0);
        activate(1'b1, 2, 1'b1, 0);
        activate(1'b1, 0, 1'b1, 1);
        activate(1'b1, 1, 1'b0, 2);
        repeat (10)
            activate(1'(rnd(8) != 0), rnd(3), 1'(rnd(2)), rnd(3));
        stop_test();
    end
endmodule
`default_nettype wire
